//--- core/drc_top.sv
// drc_top: AXI4-Lite register front end of a 32-level ratiometric reference converter.
// assumes one 250 MHz clock, synchronous active-low reset, and a ladder outside.
//
// Our own choices: register access over AXI4-Lite and the register addresses.
`default_nettype none
module drc_top
  import drc_pkg::*;
(
  // clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // axi4-lite write address
  input  wire logic [DRC_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // axi4-lite read address
  input  wire logic [DRC_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  // axi4-lite read data
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // power state
  input  wire logic                  sleep_wake,
  // ladder and pin
  output drc_analog_t                ladder_ctrl,
  input  wire logic                  pin_digital_in,
  output logic                       pin_digital_read
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic                  aw_held;
    logic [DRC_ADDR_W-1:0] aw_addr;
    logic                  w_held;
    logic [31:0]           w_data;
    logic [3:0]            w_strb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [1:0]            rresp;
    logic [31:0]           rdata;
    logic [7:0]            main;
    logic [7:0]            level;
    logic                  pin_read;
  } drc_state_t;

  drc_state_t s_q;
  drc_state_t s_d;
  drc_ctrl_t  ctrl;

  // ------------------------------------------------------------------
  // control fields
  // ------------------------------------------------------------------
  always_comb begin
    ctrl.converter_enable        = s_q.main[DRC_BIT_EN];
    ctrl.low_power_source_select = s_q.main[DRC_BIT_LPS];
    ctrl.pin_output_enable       = s_q.main[DRC_BIT_OE];
    ctrl.positive_source_select  = s_q.main[DRC_PSS_HI:DRC_PSS_LO];
    ctrl.negative_source_select  = s_q.main[DRC_BIT_NSS];
    ctrl.level_code              = s_q.level[DRC_LVL_W-1:0];
  end

  // ------------------------------------------------------------------
  // bus and register logic
  // ------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    if (s_axi_awvalid && !s_q.aw_held) begin
      s_d.aw_held = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_q.w_held) begin
      s_d.w_held = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    // write commits once address and data are both held and no response pends
    if (s_q.aw_held && s_q.w_held && !s_q.bvalid) begin
      s_d.aw_held = 1'b0;
      s_d.w_held  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = DRC_RESP_OKAY;
      case (s_q.aw_addr)
        DRC_OFF_MAIN: begin
          if (s_q.w_strb[0]) begin
            s_d.main = s_q.w_data[7:0] & DRC_MAIN_MASK;
          end
        end
        DRC_OFF_LEVEL: begin
          if (s_q.w_strb[0]) begin
            s_d.level = s_q.w_data[7:0] & DRC_LEVEL_MASK;
          end
        end
        DRC_OFF_STAT: begin
          s_d.bresp = DRC_RESP_SLVERR;
        end
        default: begin
          s_d.bresp = DRC_RESP_SLVERR;
        end
      endcase
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !s_q.rvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = DRC_RESP_OKAY;
      s_d.rdata  = '0;
      case (s_axi_araddr)
        DRC_OFF_MAIN: begin
          s_d.rdata[7:0] = s_q.main & DRC_MAIN_MASK;
        end
        DRC_OFF_LEVEL: begin
          s_d.rdata[7:0] = s_q.level & DRC_LEVEL_MASK;
        end
        DRC_OFF_STAT: begin
          // live ladder state as presented outside
          s_d.rdata[$bits(drc_analog_t)-1:0] = ladder_ctrl;
        end
        default: begin
          s_d.rresp = DRC_RESP_SLVERR;
        end
      endcase
    end
    // wake has no effect in this block; register contents are kept
    if (sleep_wake) begin
      s_d.main = s_d.main;
    end
    s_d.pin_read = ctrl.pin_output_enable ? 1'b0 : pin_digital_in;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q       <= '0;
      s_q.main  <= DRC_RST_MAIN;
      s_q.level <= DRC_RST_LEVEL;
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------------
  // ladder controls
  // ------------------------------------------------------------------
  drc_ladder_map u_map (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ctrl    (ctrl),
    .ana     (ladder_ctrl)
  );

  assign s_axi_awready    = !s_q.aw_held;
  assign s_axi_wready     = !s_q.w_held;
  assign s_axi_bvalid     = s_q.bvalid;
  assign s_axi_bresp      = s_q.bresp;
  assign s_axi_arready    = !s_q.rvalid;
  assign s_axi_rvalid     = s_q.rvalid;
  assign s_axi_rresp      = s_q.rresp;
  assign s_axi_rdata      = s_q.rdata;
  assign pin_digital_read = s_q.pin_read;
endmodule
`default_nettype wire

//--- core/drc_pkg.sv
// drc_pkg: register map, field layout, reset values and types of the reference control block.
// assumes a 32-bit AXI4-Lite register bus with byte addresses.
`default_nettype none
package drc_pkg;
  // ------------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------------
  localparam logic [3:0] DRC_OFF_MAIN  = 4'h0;
  localparam logic [3:0] DRC_OFF_LEVEL = 4'h4;
  localparam logic [3:0] DRC_OFF_STAT  = 4'h8;
  localparam int         DRC_ADDR_W    = 4;
  // ------------------------------------------------------------------
  // field layout
  // ------------------------------------------------------------------
  localparam int DRC_BIT_EN   = 7;
  localparam int DRC_BIT_LPS  = 6;
  localparam int DRC_BIT_OE   = 5;
  localparam int DRC_PSS_HI   = 3;
  localparam int DRC_PSS_LO   = 2;
  localparam int DRC_BIT_NSS  = 0;
  localparam int DRC_LVL_W    = 5;
  localparam logic [7:0] DRC_MAIN_MASK  = 8'hED;
  localparam logic [7:0] DRC_LEVEL_MASK = 8'h1F;
  localparam logic [7:0] DRC_RST_MAIN   = 8'h00;
  localparam logic [7:0] DRC_RST_LEVEL  = 8'h00;
  localparam int DRC_LEVELS = 32;
  localparam logic [4:0] DRC_LVL_FULL = 5'h1F;
  localparam logic [4:0] DRC_LVL_ZERO = 5'h00;
  // ------------------------------------------------------------------
  // encodings
  // ------------------------------------------------------------------
  localparam logic [1:0] DRC_PSS_SUPPLY = 2'h0;
  localparam logic [1:0] DRC_PSS_EXTREF = 2'h1;
  localparam logic [1:0] DRC_PSS_FIXED  = 2'h2;
  localparam logic [1:0] DRC_PSS_RSVD   = 2'h3;
  localparam logic [1:0] DRC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] DRC_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic       converter_enable;
    logic       low_power_source_select;
    logic       pin_output_enable;
    logic [1:0] positive_source_select;
    logic       negative_source_select;
    logic [4:0] level_code;
  } drc_ctrl_t;

  typedef struct packed {
    logic       ladder_enable;
    logic       pos_source_connect;
    logic       neg_source_connect;
    logic [1:0] pos_source;
    logic       neg_source;
    logic [4:0] ladder_tap;
    logic       pin_route;
    logic       pin_digital_override;
    logic       clamp_pos;
    logic       clamp_neg;
  } drc_analog_t;
endpackage
`default_nettype wire

//--- core/drc_ladder_map.sv
// drc_ladder_map: turns the control fields into registered ladder and pin controls.
// assumes a synchronous active-low reset and control fields already held in registers.
`default_nettype none
module drc_ladder_map
  import drc_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // control fields
  input  wire drc_ctrl_t   ctrl,
  // analog controls
  output drc_analog_t      ana
);
  drc_analog_t ana_q;
  drc_analog_t ana_d;

  always_comb begin
    ana_d                         = '0;
    ana_d.ladder_enable           = ctrl.converter_enable;
    ana_d.ladder_tap              = ctrl.level_code;
    ana_d.pos_source              = ctrl.positive_source_select;
    ana_d.neg_source              = ctrl.negative_source_select;
    ana_d.pin_route               = ctrl.pin_output_enable;
    ana_d.pin_digital_override    = ctrl.pin_output_enable;
    ana_d.neg_source_connect      = ctrl.converter_enable | ~ctrl.low_power_source_select;
    ana_d.pos_source_connect      = ctrl.converter_enable | ctrl.low_power_source_select;
    ana_d.clamp_pos               = ~ctrl.converter_enable & ctrl.low_power_source_select
                                    & (ctrl.level_code == DRC_LVL_FULL);
    ana_d.clamp_neg               = ~ctrl.converter_enable & ~ctrl.low_power_source_select
                                    & (ctrl.level_code == DRC_LVL_ZERO);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ana_q <= '0;
    end else begin
      ana_q <= ana_d;
    end
  end

  assign ana = ana_q;
endmodule
`default_nettype wire

//--- verification/drc_top_asserts.sv
// drc_top_asserts: timing checks on the bus answers and ladder outputs of drc_top.
// assumes it is bound onto drc_top and sees only its ports.
`default_nettype none
module drc_top_asserts
  import drc_pkg::*;
(
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  // ladder and pin
  input wire drc_analog_t ladder_ctrl,
  input wire logic        pin_digital_read
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence ld_change;
    $changed(ladder_ctrl) && $past(aresetn, 2);
  endsequence
  chk_write_answer: assert property (wr_take |-> ##2 s_axi_bvalid) else $error("write answer late");
  chk_ladder_after_wr: assert property (ld_change |-> $past(s_axi_bvalid))
    else $error("ladder moved without a write");
  chk_pin_reads_zero: assert property (ladder_ctrl.pin_route |-> !pin_digital_read)
    else $error("routed pin read not zero");
  chk_route_override: assert property (ladder_ctrl.pin_route |-> ladder_ctrl.pin_digital_override)
    else $error("routed pin not overridden");
  chk_enabled_both: assert property (ladder_ctrl.ladder_enable |->
    ladder_ctrl.pos_source_connect && ladder_ctrl.neg_source_connect) else $error("source cut while on");
  chk_lowpower_one: assert property ($past(aresetn) && !ladder_ctrl.ladder_enable |->
    ladder_ctrl.pos_source_connect ^ ladder_ctrl.neg_source_connect) else $error("bad low power cut");
  chk_reset_clear: assert property (@(posedge aclk) disable iff (1'h0) !aresetn |=>
    ladder_ctrl == '0 && !s_axi_bvalid && !s_axi_rvalid) else $error("reset left state");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
  chk_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:15] == '0)
    else $error("upper read bits set");
endmodule
bind drc_top drc_top_asserts u_asserts (.*);
`default_nettype wire

//--- verification/drc_ladder_model.sv
// drc_ladder_model: behavioural resistor ladder and output pin of the converter.
// assumes source levels in millivolts given as parameters.
`default_nettype none
module drc_ladder_model
  import drc_pkg::*;
#(
  parameter int PS = 3300,
  parameter int PE = 2500,
  parameter int PF = 2048,
  parameter int NE = 500
)
(
  // clock and ladder
  input wire logic        aclk,
  input wire drc_analog_t ladder_ctrl,
  // pin side
  input wire logic        ext_level,
  output logic            pin_digital_in,
  output int              vout_mv
);
  timeunit 1ns;
  timeprecision 1ps;
  int   pos;
  int   neg;
  logic flip_q = 1'h0;
  always_ff @(posedge aclk) flip_q <= !flip_q;
  // routed pin carries analog, detector sees noise
  assign pin_digital_in = ladder_ctrl.pin_route ? flip_q : ext_level;
  always_comb begin
    pos = (ladder_ctrl.pos_source == DRC_PSS_SUPPLY) ? PS : (ladder_ctrl.pos_source == DRC_PSS_EXTREF) ? PE : PF;
    neg = ladder_ctrl.neg_source ? NE : 0;
    if (ladder_ctrl.ladder_enable) vout_mv = neg + (pos - neg) * int'(ladder_ctrl.ladder_tap) / 32;
    else if (ladder_ctrl.pos_source_connect && ladder_ctrl.ladder_tap == DRC_LVL_FULL) vout_mv = pos;
    else if (ladder_ctrl.neg_source_connect && ladder_ctrl.ladder_tap == DRC_LVL_ZERO) vout_mv = neg;
    else vout_mv = -1;
  end
endmodule
`default_nettype wire

//--- verification/dac_reference_control_tb.sv
// dac_reference_control_tb: drives drc_top over AXI4-Lite and judges registers, ladder and pin.
// assumes drc_pkg, the ladder model and the checker bind are compiled alongside.
`default_nettype none
module dac_reference_control_tb
  import drc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PS = 3300, PE = 2500, PF = 2048, NE = 500;
  logic aclk = 1'h0, aresetn = 1'h0, sleep_wake = 1'h0, ext_level = 1'h0;
  logic [DRC_ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pin_digital_in, pin_digital_read;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  drc_analog_t ladder_ctrl;
  int vout_mv, errors = 0, checks_done = 0, cyc = 0;
  drc_top dut (.*);
  drc_ladder_model #(.PS(PS), .PE(PE), .PF(PF), .NE(NE)) u_model (.aclk(aclk), .ladder_ctrl(ladder_ctrl),
    .ext_level(ext_level), .pin_digital_in(pin_digital_in), .vout_mv(vout_mv));
  initial forever #2 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors = errors + 1;
      report_and_stop();
    end
  end
  task automatic report_and_stop;
    $display("errors=%0d checks_done=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [DRC_ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er);
    logic       a_ok;
    logic       w_ok;
    logic       b_ok;
    logic [1:0] resp;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    // ready and answer are looked at settled, then acted on at the edge
    do begin
      #1;
      a_ok = s_axi_awready;
      w_ok = s_axi_wready;
      b_ok = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge aclk);
      if (a_ok) s_axi_awvalid <= 1'h0;
      if (w_ok) s_axi_wvalid <= 1'h0;
    end while (!b_ok);
    s_axi_bready <= 1'h0;
    chk(resp, er);
  endtask
  task automatic rd(input logic [DRC_ADDR_W-1:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic        a_ok;
    logic        r_ok;
    logic [31:0] data;
    logic [1:0]  resp;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      #1;
      a_ok = s_axi_arready;
      r_ok = s_axi_rvalid;
      data = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
      if (a_ok) s_axi_arvalid <= 1'h0;
    end while (!r_ok);
    s_axi_rready <= 1'h0;
    chk(data, ed);
    chk(resp, er);
  endtask
  task automatic settle;
    repeat (2) @(posedge aclk);
    #1;
  endtask
  task automatic t_regs;
    rd(DRC_OFF_MAIN, 32'h0, DRC_RESP_OKAY);
    rd(DRC_OFF_LEVEL, 32'h0, DRC_RESP_OKAY);
    wr(DRC_OFF_MAIN, 32'hFFFF_FFF2, DRC_RESP_OKAY);
    rd(DRC_OFF_MAIN, 32'hE0, DRC_RESP_OKAY);
    wr(DRC_OFF_LEVEL, 32'hFF, DRC_RESP_OKAY);
    rd(DRC_OFF_LEVEL, 32'h1F, DRC_RESP_OKAY);
    rd(DRC_OFF_STAT, 32'h71FC, DRC_RESP_OKAY);
    wr(DRC_OFF_STAT, 32'h0, DRC_RESP_SLVERR);
    s_axi_wstrb <= 4'hE;
    wr(DRC_OFF_MAIN, 32'h0, DRC_RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rd(DRC_OFF_MAIN, 32'hE0, DRC_RESP_OKAY);
    wr(4'hC, 32'h0, DRC_RESP_SLVERR);
    rd(4'hC, 32'h0, DRC_RESP_SLVERR);
  endtask
  task automatic t_codes;
    wr(DRC_OFF_LEVEL, 32'h10, DRC_RESP_OKAY);
    for (int i = 0; i < 6; i++) begin
      int p;
      p = (i < 2) ? PS : (i < 4) ? PE : PF;
      wr(DRC_OFF_MAIN, 32'h80 | (i / 2) << 2 | i % 2, DRC_RESP_OKAY);
      settle();
      chk({ladder_ctrl.ladder_enable, ladder_ctrl.pos_source, ladder_ctrl.neg_source}, 4'h8 | (i / 2) << 1 | i % 2);
      chk(vout_mv, (i % 2) * NE + (p - (i % 2) * NE) * 16 / 32);
    end
  endtask
  task automatic t_pin;
    ext_level <= 1'h1;
    wr(DRC_OFF_MAIN, 32'hA0, DRC_RESP_OKAY);
    settle();
    repeat (3) begin
      chk({ladder_ctrl.pin_route, pin_digital_read}, 2'h2);
      @(posedge aclk);
      #1;
    end
    wr(DRC_OFF_MAIN, 32'h80, DRC_RESP_OKAY);
    settle();
    chk({ladder_ctrl.pin_route, pin_digital_read}, 2'h1);
  endtask
  task automatic t_clamp;
    wr(DRC_OFF_MAIN, 32'h48, DRC_RESP_OKAY);
    wr(DRC_OFF_LEVEL, 32'h1F, DRC_RESP_OKAY);
    settle();
    chk(vout_mv, PF);
    chk({ladder_ctrl.pos_source_connect, ladder_ctrl.neg_source_connect, ladder_ctrl.clamp_pos}, 3'h5);
    wr(DRC_OFF_MAIN, 32'h01, DRC_RESP_OKAY);
    wr(DRC_OFF_LEVEL, 32'h00, DRC_RESP_OKAY);
    settle();
    chk(vout_mv, NE);
    chk({ladder_ctrl.pos_source_connect, ladder_ctrl.neg_source_connect, ladder_ctrl.clamp_neg}, 3'h3);
  endtask
  task automatic t_sleep_reset;
    sleep_wake <= 1'h1;
    @(posedge aclk);
    sleep_wake <= 1'h0;
    rd(DRC_OFF_MAIN, 32'h01, DRC_RESP_OKAY);
    wr(DRC_OFF_MAIN, 32'hA4, DRC_RESP_OKAY);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    rd(DRC_OFF_MAIN, 32'h0, DRC_RESP_OKAY);
    chk({ladder_ctrl.ladder_enable, ladder_ctrl.pin_route, ladder_ctrl.ladder_tap}, 7'h0);
  endtask
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    t_regs();
    t_codes();
    t_pin();
    t_clamp();
    t_sleep_reset();
    report_and_stop();
  end
endmodule
`default_nettype wire
